// *** logic/csr_pkg.sv ***
package csr_pkg;
  // Register byte offsets
  localparam logic [7:0] ADDR_OPTIONS = 8'h00;
  localparam logic [7:0] ADDR_CONTROL = 8'h04;
  localparam logic [7:0] ADDR_LENGTH = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;
  // Option field positions
  localparam int OPT_DONE_LATE = 0;
  localparam int OPT_RESET_LATE = 1;
  localparam int OPT_PULLNONE = 2;
  localparam int OPT_DONE_ALIGN = 3;
  localparam int OPT_RB_LSB = 4;
  localparam int OPT_OSC_LSB = 6;
  localparam int OPT_WIDTH = 8;
  // Control field positions
  localparam int CTL_RECONFIG = 0;
  // Status field positions
  localparam int ST_DONE = 0;
  localparam int ST_IO = 1;
  localparam int ST_RESET = 2;
  localparam int ST_BUSY = 3;
  localparam int ST_ONCE = 4;
  localparam int ST_PHASE_LSB = 5;
  // Readback modes
  localparam logic [1:0] RB_NEVER = 2'h0;
  localparam logic [1:0] RB_ONCE = 2'h1;
  localparam logic [1:0] RB_COMMAND = 2'h2;
  // Oscillator modes
  localparam logic [1:0] OSC_OFF = 2'h0;
  localparam logic [1:0] OSC_ON = 2'h1;
  localparam logic [1:0] OSC_HALF = 2'h2;
  // Reset values: early done, late reset, pull-up, length alignment, on-command, osc off
  localparam logic [7:0] OPTIONS_RESET = 8'h22;
  localparam logic [15:0] LENGTH_RESET = 16'h0040;
  // Extra bit counted under done alignment
  localparam logic [15:0] DONE_ALIGN_EXTRA = 16'h0001;
  // Configuration memory
  localparam int MEM_DEPTH = 64;
  localparam int MEM_AW = 6;
  localparam int CNT_W = 16;
  // Startup steps
  localparam logic [1:0] STEP_C1 = 2'h0;
  localparam logic [1:0] STEP_C2 = 2'h1;
  localparam logic [1:0] STEP_C3 = 2'h2;
  typedef enum logic [1:0] {
    PH_LOAD = 2'b00,
    PH_START = 2'b01,
    PH_USER = 2'b10
  } csr_phase_t;
endpackage : csr_pkg

// *** logic/csr_top.sv ***
// Our own choices: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ps
// Behaviour
// - Done pin released one cclk before I/O active (early) or after (late).
// - Internal reset removed one cclk before or after I/O goes active.
// - With late reset, outputs go active while flip-flops stay in reset.
// - Internal pull-up on done pin unless the no-pull-up option is chosen.
// - Rising readback trigger after configuration starts readback when permitted.
// - Readback bits leave serially, one per external cclk pulse.
// - Readback modes: never, once only, or on every trigger (default).
// - Crystal oscillator off (default), on, or on with output halved.
// - Length count from length alignment (default) or done alignment.

module csr_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 2
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] store [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [PW:0] count;
  logic [PW-1:0] next_wr_ptr;
  logic [PW-1:0] next_rd_ptr;
  logic [PW:0] next_count;
  logic push;
  logic pop;

  assign in_ready = (count != (PW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data = store[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count = count;
    if (push) begin
      next_wr_ptr = (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
    end
    if (pop) begin
      next_rd_ptr = (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      store[wr_ptr] <= in_data;
    end
  end
endmodule : csr_fifo

module csr_top (
  input wire logic clk,
  input wire logic reset,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic cclk_pin,
  input wire logic config_data_pin,
  input wire logic readback_trigger_pin,
  output logic readback_data,
  output logic readback_valid,
  input wire logic readback_ready,
  output logic done_o,
  output logic done_oe,
  output logic done_pullup_en,
  output logic io_block_active,
  output logic internal_reset,
  input wire logic xtal_in,
  output logic osc_enable,
  output logic osc_out
);
  logic [7:0] options;
  logic [15:0] length_count;
  csr_pkg::csr_phase_t phase;
  logic [1:0] step;
  logic [15:0] cnt;
  logic [15:0] rb_idx;
  logic rb_busy;
  logic once_used;
  logic done_released;
  logic cclk_prev;
  logic trig_prev;
  logic xtal_prev;
  logic osc_half;
  logic ack;
  logic [31:0] rdata;
  logic cfg_mem [csr_pkg::MEM_DEPTH];

  logic [7:0] next_options;
  logic [15:0] next_length_count;
  csr_pkg::csr_phase_t next_phase;
  logic [1:0] next_step;
  logic [15:0] next_cnt;
  logic [15:0] next_rb_idx;
  logic next_rb_busy;
  logic next_once_used;
  logic next_done_released;
  logic next_io_active;
  logic next_internal_reset;
  logic next_osc_half;
  logic next_osc_out;
  logic next_ack;
  logic [31:0] next_rdata;

  logic done_late;
  logic reset_late;
  logic [1:0] rb_mode;
  logic [1:0] osc_mode;
  logic [15:0] target;
  logic cclk_rise;
  logic trig_rise;
  logic wb_req;
  logic wr_en;
  logic rb_allowed;
  logic rb_start;
  logic push_valid;
  logic push_ready;
  logic push_data;

  assign done_late = options[csr_pkg::OPT_DONE_LATE];
  assign reset_late = options[csr_pkg::OPT_RESET_LATE];
  assign rb_mode = options[csr_pkg::OPT_RB_LSB +: 2];
  assign osc_mode = options[csr_pkg::OPT_OSC_LSB +: 2];
  assign cclk_rise = cclk_pin && !cclk_prev;
  assign trig_rise = readback_trigger_pin && !trig_prev;
  assign wb_req = wb_cyc_i && wb_stb_i && !ack;
  assign wr_en = wb_req && wb_we_i;

  // Length alignment counts the programmed bits, done alignment one more
  assign target = options[csr_pkg::OPT_DONE_ALIGN] ?
                  length_count + csr_pkg::DONE_ALIGN_EXTRA : length_count;

  assign rb_allowed = (rb_mode == csr_pkg::RB_COMMAND) ||
                      (rb_mode == csr_pkg::RB_ONCE && !once_used);
  assign rb_start = trig_rise && (phase == csr_pkg::PH_USER) && rb_allowed && !rb_busy;
  assign push_valid = rb_busy && cclk_rise;
  assign push_data = cfg_mem[rb_idx[csr_pkg::MEM_AW-1:0]];

  // Open-drain done pin driven low until released
  assign done_o = 1'b0;
  assign done_oe = !done_released;
  assign done_pullup_en = !options[csr_pkg::OPT_PULLNONE];
  assign osc_enable = (osc_mode == csr_pkg::OSC_ON) || (osc_mode == csr_pkg::OSC_HALF);
  assign wb_ack_o = ack;
  assign wb_dat_o = rdata;

  csr_fifo #(
    .WIDTH(1),
    .DEPTH(2)
  ) csr_fifo_i (
    .clk(clk),
    .reset(reset),
    .in_valid(push_valid),
    .in_ready(push_ready),
    .in_data(push_data),
    .out_valid(readback_valid),
    .out_ready(readback_ready),
    .out_data(readback_data)
  );

  // Wishbone slave
  always_comb begin
    next_ack = wb_req;
    next_rdata = rdata;
    next_options = options;
    next_length_count = length_count;
    if (wb_req && !wb_we_i) begin
      case (wb_adr_i)
        csr_pkg::ADDR_OPTIONS: next_rdata = {24'h000000, options};
        csr_pkg::ADDR_LENGTH: next_rdata = {16'h0000, length_count};
        csr_pkg::ADDR_STATUS: begin
          next_rdata = '0;
          next_rdata[csr_pkg::ST_DONE] = done_released;
          next_rdata[csr_pkg::ST_IO] = io_block_active;
          next_rdata[csr_pkg::ST_RESET] = internal_reset;
          next_rdata[csr_pkg::ST_BUSY] = rb_busy;
          next_rdata[csr_pkg::ST_ONCE] = once_used;
          next_rdata[csr_pkg::ST_PHASE_LSB +: 2] = phase;
        end
        default: next_rdata = '0;
      endcase
    end
    // Options only change while configuration data is loading
    if (wr_en && phase == csr_pkg::PH_LOAD) begin
      if (wb_adr_i == csr_pkg::ADDR_OPTIONS && wb_sel_i[0]) begin
        next_options = wb_dat_i[7:0];
      end
      if (wb_adr_i == csr_pkg::ADDR_LENGTH) begin
        if (wb_sel_i[0]) begin
          next_length_count[7:0] = wb_dat_i[7:0];
        end
        if (wb_sel_i[1]) begin
          next_length_count[15:8] = wb_dat_i[15:8];
        end
      end
    end
  end

  // Configuration load, startup sequence and readback
  always_comb begin
    next_phase = phase;
    next_step = step;
    next_cnt = cnt;
    next_done_released = done_released;
    next_io_active = io_block_active;
    next_internal_reset = internal_reset;
    next_rb_idx = rb_idx;
    next_rb_busy = rb_busy;
    next_once_used = once_used;
    case (phase)
      csr_pkg::PH_LOAD: begin
        if (cclk_rise) begin
          next_cnt = cnt + 1'b1;
          if (cnt + 1'b1 >= target) begin
            next_phase = csr_pkg::PH_START;
            next_step = csr_pkg::STEP_C1;
          end
        end
      end
      csr_pkg::PH_START: begin
        if (cclk_rise) begin
          next_step = step + 1'b1;
          case (step)
            csr_pkg::STEP_C1: begin
              next_done_released = !done_late;
              next_internal_reset = reset_late;
            end
            csr_pkg::STEP_C2: next_io_active = 1'b1;
            csr_pkg::STEP_C3: begin
              next_done_released = 1'b1;
              next_internal_reset = 1'b0;
              next_phase = csr_pkg::PH_USER;
            end
            default: next_step = csr_pkg::STEP_C1;
          endcase
        end
      end
      csr_pkg::PH_USER: begin
        if (rb_start) begin
          next_rb_busy = 1'b1;
          next_rb_idx = '0;
          // Only a single-shot readback uses up the one permitted request
          if (rb_mode == csr_pkg::RB_ONCE) begin
            next_once_used = 1'b1;
          end
        end else if (push_valid && push_ready) begin
          next_rb_idx = rb_idx + 1'b1;
          if (rb_idx + 1'b1 >= target) begin
            next_rb_busy = 1'b0;
          end
        end
      end
      default: next_phase = csr_pkg::PH_LOAD;
    endcase
    if (wr_en && wb_adr_i == csr_pkg::ADDR_CONTROL && wb_sel_i[0] &&
        wb_dat_i[csr_pkg::CTL_RECONFIG]) begin
      next_phase = csr_pkg::PH_LOAD;
      next_cnt = '0;
      next_step = csr_pkg::STEP_C1;
      next_done_released = 1'b0;
      next_io_active = 1'b0;
      next_internal_reset = 1'b1;
      next_rb_busy = 1'b0;
    end
  end

  // Crystal oscillator output
  always_comb begin
    next_osc_half = osc_half;
    next_osc_out = 1'b0;
    case (osc_mode)
      csr_pkg::OSC_ON: next_osc_out = xtal_in;
      csr_pkg::OSC_HALF: begin
        if (xtal_in && !xtal_prev) begin
          next_osc_half = !osc_half;
        end
        next_osc_out = next_osc_half;
      end
      default: next_osc_half = 1'b0;
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ack <= 1'b0;
      rdata <= '0;
      options <= csr_pkg::OPTIONS_RESET;
      length_count <= csr_pkg::LENGTH_RESET;
      phase <= csr_pkg::PH_LOAD;
      step <= csr_pkg::STEP_C1;
      cnt <= '0;
      done_released <= 1'b0;
      io_block_active <= 1'b0;
      internal_reset <= 1'b1;
      rb_idx <= '0;
      rb_busy <= 1'b0;
      once_used <= 1'b0;
      cclk_prev <= 1'b0;
      trig_prev <= 1'b0;
      xtal_prev <= 1'b0;
      osc_half <= 1'b0;
      osc_out <= 1'b0;
    end else begin
      ack <= next_ack;
      rdata <= next_rdata;
      options <= next_options;
      length_count <= next_length_count;
      phase <= next_phase;
      step <= next_step;
      cnt <= next_cnt;
      done_released <= next_done_released;
      io_block_active <= next_io_active;
      internal_reset <= next_internal_reset;
      rb_idx <= next_rb_idx;
      rb_busy <= next_rb_busy;
      once_used <= next_once_used;
      cclk_prev <= cclk_pin;
      trig_prev <= readback_trigger_pin;
      xtal_prev <= xtal_in;
      osc_half <= next_osc_half;
      osc_out <= next_osc_out;
    end
  end

  // Configuration bits captured while loading
  always_ff @(posedge clk) begin
    if (phase == csr_pkg::PH_LOAD && cclk_rise && cnt < 16'(csr_pkg::MEM_DEPTH)) begin
      cfg_mem[cnt[csr_pkg::MEM_AW-1:0]] <= config_data_pin;
    end
  end

  a_done_early: assert property (@(posedge clk) disable iff (reset)
    $rose(io_block_active) && !done_late |-> $past(done_released) && done_released)
    else $error("done not released one cclk before io");
  a_done_late: assert property (@(posedge clk) disable iff (reset)
    $rose(done_released) && done_late && phase == csr_pkg::PH_USER |->
    io_block_active && $past(io_block_active))
    else $error("late done not after io active");
  a_reset_timing: assert property (@(posedge clk) disable iff (reset)
    $rose(io_block_active) |-> internal_reset == reset_late)
    else $error("internal reset wrong at io activation");
  a_outputs_in_reset: assert property (@(posedge clk) disable iff (reset)
    $fell(internal_reset) && reset_late && phase == csr_pkg::PH_USER |->
    $past(io_block_active))
    else $error("outputs not active before reset release");
  a_pullup_select: assert property (@(posedge clk) disable iff (reset)
    done_pullup_en != options[csr_pkg::OPT_PULLNONE])
    else $error("pull-up selection mismatch");
  a_readback_start: assert property (@(posedge clk) disable iff (reset)
    rb_start && !(wr_en && wb_adr_i == csr_pkg::ADDR_CONTROL) |=> rb_busy && rb_idx == '0)
    else $error("readback did not start");
  a_readback_advance: assert property (@(posedge clk) disable iff (reset)
    rb_busy && push_valid && push_ready && !wr_en |=>
    rb_idx == $past(rb_idx) + 16'h0001)
    else $error("readback bit index did not advance");
  a_readback_once: assert property (@(posedge clk) disable iff (reset)
    (rb_mode == csr_pkg::RB_NEVER || (rb_mode == csr_pkg::RB_ONCE && once_used)) && !rb_busy
    |=> !rb_busy)
    else $error("blocked readback started");
  a_osc_off: assert property (@(posedge clk) disable iff (reset)
    osc_mode == csr_pkg::OSC_OFF ##1 osc_mode == csr_pkg::OSC_OFF |-> !osc_out && !osc_enable)
    else $error("oscillator active while off");
  a_length_reached: assert property (@(posedge clk) disable iff (reset)
    phase == csr_pkg::PH_LOAD && cclk_rise && cnt + 16'h0001 >= target && !wr_en
    |=> phase == csr_pkg::PH_START)
    else $error("startup did not begin at length count");
  a_options_static: assert property (@(posedge clk) disable iff (reset)
    phase != csr_pkg::PH_LOAD |=> $stable(options) && $stable(length_count))
    else $error("options changed outside configuration");
endmodule : csr_top

// *** verif/csr_cfg_ctrl.sv ***
`timescale 1ns/1ps
module csr_cfg_ctrl (
  input wire logic clk,
  output logic cclk_pin,
  output logic config_data_pin,
  output logic readback_trigger_pin
);
  initial begin
    cclk_pin = 1'b0;
    config_data_pin = 1'b0;
    readback_trigger_pin = 1'b0;
  end
  // One cclk pulse per bit wanted, two clk low then two clk high
  task automatic pulse(input logic d);
    @(posedge clk) config_data_pin <= d;
    @(posedge clk);
    @(posedge clk) cclk_pin <= 1'b1;
    @(posedge clk);
    @(posedge clk) begin
      cclk_pin <= 1'b0;
      config_data_pin <= ~d;
    end
  endtask : pulse
  // High pulse of three clk on the trigger line, then back low
  task automatic trigger();
    @(posedge clk) readback_trigger_pin <= 1'b1;
    repeat (3) @(posedge clk);
    readback_trigger_pin <= 1'b0;
  endtask : trigger
endmodule : csr_cfg_ctrl

// *** verif/config_startup_readback_ctrl_tb.sv ***
`timescale 1ns/1ps
module config_startup_readback_ctrl_tb;
  localparam int LEN = 8;
  logic clk, reset, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, readback_data, readback_valid;
  logic [7:0] wb_adr_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic cclk_pin, config_data_pin, readback_trigger_pin, readback_ready, done_oe;
  logic done_pullup_en, io_block_active, internal_reset, xtal_in, osc_enable, stall_en, once;
  logic done_o, osc_out;
  logic [15:0] lfsr_s;
  logic mem [0:63];
  logic [31:0] rd_q [$];
  logic rb_q [$];
  int error_cnt = 0;
  int n_tests = 0;
  csr_top csr_top_i (.clk(clk), .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hf), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cclk_pin(cclk_pin),
    .config_data_pin(config_data_pin), .readback_trigger_pin(readback_trigger_pin),
    .readback_data(readback_data), .readback_valid(readback_valid),
    .readback_ready(readback_ready), .done_o(done_o), .done_oe(done_oe),
    .done_pullup_en(done_pullup_en), .io_block_active(io_block_active),
    .internal_reset(internal_reset), .xtal_in(xtal_in), .osc_enable(osc_enable),
    .osc_out(osc_out));
  csr_cfg_ctrl csr_cfg_ctrl_i (.clk(clk), .cclk_pin(cclk_pin),
    .config_data_pin(config_data_pin), .readback_trigger_pin(readback_trigger_pin));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next
  // Random crystal input and receiver stalls
  always @(posedge clk) begin
    lfsr_s <= lfsr_next(lfsr_s);
    xtal_in <= lfsr_s[3];
    readback_ready <= lfsr_s[0] | ~stall_en;
  end
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : wrap_up
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    if (got !== exp) begin
      $display("BAD %s expected %h seen %h", nm, exp, got);
      error_cnt++;
    end
    n_tests++;
  endtask : chk
  task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] d);
    int n;
    @(posedge clk) begin
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_dat_i <= d;
    end
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) begin
      chk("wb_timeout", 32'h0, 32'h1);
      wrap_up();
    end
    @(posedge clk) begin
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
    end
    @(posedge clk);
  endtask : wb_xfer
  task automatic rd_exp(input logic [7:0] adr, input logic [31:0] exp);
    rd_q.push_back(exp);
    wb_xfer(1'b0, adr, 32'h0);
  endtask : rd_exp
  // Read data is compared at the single ack cycle
  always @(negedge clk) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
      if (rd_q.size() == 0) chk("rd_extra", 32'h1, 32'h0);
      else chk("rd_data", rd_q.pop_front(), wb_dat_o);
    end
  end
  // Readback bits are compared as the receiver takes them
  always @(negedge clk) begin
    if (readback_valid === 1'b1 && readback_ready === 1'b1) begin
      if (rb_q.size() == 0) chk("rb_extra", 32'h1, 32'h0);
      else chk("rb_bit", {31'h0, rb_q.pop_front()}, {31'h0, readback_data});
    end
  end
  task automatic readback(input logic ok);
    if (ok) for (int i = 0; i < LEN; i++) rb_q.push_back(mem[i]);
    csr_cfg_ctrl_i.trigger();
    stall_en <= 1'b1;
    repeat (4 * LEN) csr_cfg_ctrl_i.pulse(1'b0);
    stall_en <= 1'b0;
    repeat (8) @(posedge clk);
    chk("rb_left", 32'h0, 32'(rb_q.size()));
  endtask : readback
  // Oscillator output against the crystal input sampled one clock earlier
  task automatic osc_chk(input logic [1:0] m);
    logic x, xp, op, e;
    @(posedge clk);
    xp = xtal_in;
    @(posedge clk);
    x = xtal_in;
    op = osc_out;
    repeat (16) begin
      @(posedge clk);
      e = (m == csr_pkg::OSC_ON) ? x : (m == csr_pkg::OSC_HALF) ? op ^ (x & ~xp) : 1'b0;
      chk("osc_out", {31'h0, e}, {31'h0, osc_out});
      xp = x;
      x = xtal_in;
      op = osc_out;
    end
  endtask : osc_chk
  task automatic run_case(input int k);
    logic [7:0] o;
    logic b;
    int tgt;
    o = {2'(k % 3), (k == 1) ? csr_pkg::RB_ONCE : (k == 2) ? csr_pkg::RB_NEVER :
      csr_pkg::RB_COMMAND, k == 2, k == 2, 2'(k)};
    wb_xfer(1'b1, csr_pkg::ADDR_OPTIONS, {24'h0, o});
    rd_exp(csr_pkg::ADDR_OPTIONS, {24'h0, o});
    chk("pins", {29'h0, 1'b0, ~o[2], o[7:6] != csr_pkg::OSC_OFF}, {29'h0, done_o,
      done_pullup_en, osc_enable});
    osc_chk(o[7:6]);
    tgt = LEN + int'(o[3]);
    for (int i = 0; i < tgt; i++) begin
      b = lfsr_s[7];
      mem[i] = b;
      csr_cfg_ctrl_i.pulse(b);
    end
    for (int s = 0; s < 4; s++) begin
      if (s > 0) csr_cfg_ctrl_i.pulse(1'b0);
      repeat (2) @(negedge clk);
      chk("start", {29'h0, o[1] ? s < 3 : s < 1, s >= 2, o[0] ? s < 3 : s < 1},
        {29'h0, internal_reset, io_block_active, done_oe});
    end
    wb_xfer(1'b1, csr_pkg::ADDR_OPTIONS, {24'h0, ~o});
    rd_exp(csr_pkg::ADDR_OPTIONS, {24'h0, o});
    for (int t = 0; t < 2; t++) begin
      readback(o[5:4] == csr_pkg::RB_COMMAND || (o[5:4] == csr_pkg::RB_ONCE && !once));
      if (o[5:4] == csr_pkg::RB_ONCE) once = 1'b1;
    end
    rd_exp(csr_pkg::ADDR_STATUS, {27'h0, once, 4'h0} | 32'h43);
    wb_xfer(1'b1, csr_pkg::ADDR_CONTROL, 32'h1);
    rd_exp(csr_pkg::ADDR_STATUS, {27'h0, once, 4'h4});
  endtask : run_case
  initial begin
    reset = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_dat_i = 32'h0;
    xtal_in = 1'b0;
    readback_ready = 1'b1;
    stall_en = 1'b0;
    once = 1'b0;
    lfsr_s = 16'hf605;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    rd_exp(csr_pkg::ADDR_OPTIONS, 32'h22);
    rd_exp(csr_pkg::ADDR_LENGTH, 32'h40);
    rd_exp(csr_pkg::ADDR_STATUS, 32'h4);
    rd_exp(8'h10, 32'h0);
    wb_xfer(1'b1, csr_pkg::ADDR_LENGTH, 32'(LEN));
    rd_exp(csr_pkg::ADDR_LENGTH, 32'(LEN));
    for (int k = 0; k < 4; k++) run_case(k);
    wrap_up();
  end
endmodule : config_startup_readback_ctrl_tb
